// ==== hdl/vdc_ctrl_regs.sv ====
// Control register bank of the video decoder with its AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Pin groups float per group select when soft request is set or drive pin low.
// - Soft float request resets to 0; when 1 outputs float regardless of pin.
// - With force bit 0, SECAM demodulation filter follows SECAM detection unless the manual override forces it on or off.
// - With force bit 1, SECAM demodulation filter always used.
// - Contrast setting is a signed two's complement gain adjustment on luma.
// - Brightness setting is a signed two's complement offset on luma.
// - With gain test bit 0, saturation setting is signed two's complement.
// - With gain test bit 0, saturation zero gives nominal colour; positive raises, negative lowers.
module vdc_ctrl_regs
	import vdc_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	input  wire logic              output_drive_pin_n_i,
	input  wire logic              secam_found_i,
	input  wire logic              subcarrier_found_i,
	input  wire logic              burst_ok_i,
	input  wire logic              pix_valid_i,
	input  wire vdc_pix_t          pix_i,
	output logic                   video_oe_o,
	output logic                   timing_oe_o,
	output logic                   clock_oe_o,
	output logic                   secam_filter_en_o,
	output logic                   five_tap_en_o,
	output vdc_cfg_t               cfg_o,
	output logic                   pix_valid_o,
	output vdc_pix_t               pix_o
);

	typedef struct packed {
		logic [REG_CNT-1:0][7:0] regs;
		logic                    aw_got;
		logic [IDX_W-1:0]        aw_idx;
		logic                    w_got;
		logic [7:0]              wbyte;
		logic                    wlane0;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    rvalid;
		logic [31:0]             rdata;
		logic [1:0]              rresp;
		logic                    video_oe;
		logic                    timing_oe;
		logic                    clock_oe;
		logic                    sec_filter;
	} vdc_state_t;

	localparam vdc_state_t ST_RST = '{
		regs:       REG_RST,
		aw_got:     1'b0,
		aw_idx:     '0,
		w_got:      1'b0,
		wbyte:      8'h00,
		wlane0:     1'b0,
		bvalid:     1'b0,
		bresp:      RESP_OKAY,
		rvalid:     1'b0,
		rdata:      32'h0000_0000,
		rresp:      RESP_OKAY,
		video_oe:   1'b0,
		timing_oe:  1'b0,
		clock_oe:   1'b0,
		sec_filter: 1'b0
	};

	vdc_state_t st_r;
	vdc_state_t st_nxt;

	// Bits that software may change; zero for an unmapped index
	function automatic logic [7:0] write_mask(input logic [IDX_W-1:0] idx);
		case (idx)
			IDX_FLOAT_DEMOD:  return MASK_FLOAT_DEMOD;
			IDX_LUMA_CTL:     return MASK_LUMA_CTL;
			IDX_DEMOD_STATUS: return MASK_DEMOD_CTL;
			IDX_OUT_CTL:      return MASK_OUT_CTL;
			IDX_TEST_CTL:     return MASK_TEST_CTL;
			IDX_GP_PORT, IDX_PICTURE_GAIN, IDX_LUMA_OFFSET, IDX_CHROMA_A,
			IDX_CHROMA_B, IDX_COLOR_GAIN, IDX_TINT, IDX_VERT_A: return MASK_FULL;
			default:          return 8'h00;
		endcase
	endfunction

	function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
		return write_mask(idx) != 8'h00;
	endfunction

	function automatic logic [SLOT_W-1:0] slot_of(input logic [IDX_W-1:0] idx);
		return SLOT_W'(idx - IDX_BASE);
	endfunction

	function automatic logic [7:0] reg_at(input vdc_state_t s, input logic [IDX_W-1:0] idx);
		return s.regs[slot_of(idx)];
	endfunction

	logic [IDX_W-1:0] ar_idx;
	logic [7:0]       rd_byte;
	logic             float_on;
	logic [1:0]       float_group;
	logic [1:0]       sec_manual;
	logic             sec_effective;
	logic [7:0]       float_demod_val;
	logic [7:0]       out_ctl_val;
	logic [7:0]       demod_val;
	logic [7:0]       chroma_a_val;
	logic [7:0]       test_ctl_val;
	logic [7:0]       vert_a_val;

	assign ar_idx = s_axi_araddr_i[IDX_W+1:2];

	// Whole-register views, so single fields are picked from a net and not from a call
	assign float_demod_val = reg_at(st_r, IDX_FLOAT_DEMOD);
	assign out_ctl_val     = reg_at(st_r, IDX_OUT_CTL);
	assign demod_val       = reg_at(st_r, IDX_DEMOD_STATUS);
	assign chroma_a_val    = reg_at(st_r, IDX_CHROMA_A);
	assign test_ctl_val    = reg_at(st_r, IDX_TEST_CTL);
	assign vert_a_val      = reg_at(st_r, IDX_VERT_A);

	// Handshake outputs are combinational from registered state
	assign s_axi_awready_o = !st_r.aw_got && !st_r.bvalid;
	assign s_axi_wready_o  = !st_r.w_got && !st_r.bvalid;
	assign s_axi_arready_o = !st_r.rvalid;

	always_comb begin
		st_nxt = st_r;
		rd_byte = 8'h00;

		// Write path: address and data may arrive in either order
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.aw_idx = s_axi_awaddr_i[IDX_W+1:2];
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			st_nxt.w_got  = 1'b1;
			st_nxt.wbyte  = s_axi_wdata_i[7:0];
			st_nxt.wlane0 = s_axi_wstrb_i[0];
		end
		if (st_r.aw_got && st_r.w_got) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got  = 1'b0;
			st_nxt.bvalid = 1'b1;
			if (is_mapped(st_r.aw_idx)) begin
				st_nxt.bresp = RESP_OKAY;
				if (st_r.wlane0) begin
					st_nxt.regs[slot_of(st_r.aw_idx)] =
						st_r.wbyte & write_mask(st_r.aw_idx);
				end
			end else begin
				st_nxt.bresp = RESP_SLVERR;
			end
		end
		if (st_r.bvalid && s_axi_bready_i) begin
			st_nxt.bvalid = 1'b0;
		end

		// Read path: one cycle from address acceptance to data
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			st_nxt.rvalid = 1'b1;
			if (is_mapped(ar_idx)) begin
				rd_byte = reg_at(st_r, ar_idx) & write_mask(ar_idx);
				if (ar_idx == IDX_DEMOD_STATUS) begin
					// Detector results are sampled live, never stored
					rd_byte[SUBC_FOUND_BIT] = subcarrier_found_i;
					rd_byte[SEC_FOUND_BIT]  = secam_found_i;
				end
				st_nxt.rresp = RESP_OKAY;
			end else begin
				st_nxt.rresp = RESP_SLVERR;
			end
			st_nxt.rdata = {24'h000000, rd_byte};
		end else if (st_r.rvalid && s_axi_rready_i) begin
			st_nxt.rvalid = 1'b0;
		end

		// Pin float control
		float_on = float_demod_val[FLOAT_REQ_BIT] || !output_drive_pin_n_i;
		float_group = out_ctl_val[GROUP_LO +: 2];
		st_nxt.video_oe  = 1'b1;
		st_nxt.timing_oe = 1'b1;
		st_nxt.clock_oe  = 1'b1;
		if (float_on) begin
			case (float_group)
				GRP_VIDEO: begin
					st_nxt.video_oe = 1'b0;
				end
				GRP_TIMING: begin
					st_nxt.video_oe  = 1'b0;
					st_nxt.timing_oe = 1'b0;
				end
				GRP_CLOCK: begin
					st_nxt.video_oe  = 1'b0;
					st_nxt.timing_oe = 1'b0;
					st_nxt.clock_oe  = 1'b0;
				end
				default: begin
					// Reserved group code floats nothing, so pins stay safe to probe
				end
			endcase
		end

		// SECAM filter select, honouring the manual detection override
		sec_manual = demod_val[MNSEC_LO +: 2];
		case (sec_manual)
			SEC_FORCE_NOT: sec_effective = 1'b0;
			SEC_FORCE_YES: sec_effective = 1'b1;
			default:       sec_effective = secam_found_i;
		endcase
		st_nxt.sec_filter = float_demod_val[SEC_FORCE_BIT] || sec_effective;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	vdc_adj_cfg_t adj_cfg;

	always_comb begin
		adj_cfg.contrast     = signed'(reg_at(st_r, IDX_PICTURE_GAIN));
		adj_cfg.brightness   = signed'(reg_at(st_r, IDX_LUMA_OFFSET));
		adj_cfg.saturation   = signed'(reg_at(st_r, IDX_COLOR_GAIN));
		adj_cfg.sat_unsigned = test_ctl_val[GAIN_TEST_BIT];
		adj_cfg.kill_mode    = chroma_a_val[KILL_LO +: 2];
		adj_cfg.core_mode    = chroma_a_val[CORE_LO +: 2];
	end

	vdc_pixel_adjust u_adjust (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.pix_valid_i (pix_valid_i),
		.pix_i       (pix_i),
		.burst_ok_i  (burst_ok_i),
		.cfg_i       (adj_cfg),
		.pix_valid_o (pix_valid_o),
		.pix_o       (pix_o)
	);

	assign s_axi_bvalid_o    = st_r.bvalid;
	assign s_axi_bresp_o     = st_r.bresp;
	assign s_axi_rvalid_o    = st_r.rvalid;
	assign s_axi_rdata_o     = st_r.rdata;
	assign s_axi_rresp_o     = st_r.rresp;
	assign video_oe_o        = st_r.video_oe;
	assign timing_oe_o       = st_r.timing_oe;
	assign clock_oe_o        = st_r.clock_oe;
	assign secam_filter_en_o = st_r.sec_filter;
	// The far side must keep this at 0 for lines wider than 384 pixels
	assign five_tap_en_o     = vert_a_val[FIVE_TAP_BIT];

	assign cfg_o.port_routing = reg_at(st_r, IDX_GP_PORT);
	assign cfg_o.luma_ctl     = reg_at(st_r, IDX_LUMA_CTL);
	assign cfg_o.chroma_b     = reg_at(st_r, IDX_CHROMA_B);
	assign cfg_o.demod_ctl    = demod_val[5:0];
	assign cfg_o.tint         = reg_at(st_r, IDX_TINT);
	assign cfg_o.vert_a       = reg_at(st_r, IDX_VERT_A);

endmodule

`default_nettype wire

// ==== hdl/vdc_pixel_adjust.sv ====
// Per-sample luma contrast/brightness and chroma saturation, coring and colour kill
`timescale 1ns/10ps
`default_nettype none

module vdc_pixel_adjust
	import vdc_pkg::*;
(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         pix_valid_i,
	input  wire vdc_pix_t     pix_i,
	input  wire logic         burst_ok_i,
	input  wire vdc_adj_cfg_t cfg_i,
	output logic              pix_valid_o,
	output vdc_pix_t          pix_o
);

	typedef struct packed {
		logic     valid;
		vdc_pix_t pix;
	} vdc_adj_state_t;

	vdc_adj_state_t st_r;
	vdc_adj_state_t st_nxt;

	// Saturates a scaled sample into the unsigned 8-bit code range
	function automatic logic [7:0] clamp_u8(input logic signed [19:0] v);
		if (v < 20'sd0) begin
			return 8'h00;
		end else if (v > 20'sd255) begin
			return 8'hff;
		end
		return v[7:0];
	endfunction

	logic signed [9:0]  luma_gain;
	logic signed [9:0]  color_gain;
	logic signed [9:0]  chroma_dev;
	logic signed [9:0]  cored_dev;
	logic signed [9:0]  core_thr;
	logic signed [19:0] luma_prod;
	logic signed [19:0] chroma_prod;
	logic [7:0]         chroma_scaled;

	always_comb begin
		st_nxt = st_r;
		luma_gain = UNIT_GAIN + 10'(cfg_i.contrast);
		luma_prod = signed'({2'b00, pix_i.luma}) * luma_gain;
		// Offset after gain so brightness steps stay one code each
		luma_prod = (luma_prod >>> GAIN_SHIFT) + 20'(cfg_i.brightness);
		if (cfg_i.sat_unsigned) begin
			color_gain = signed'({2'b00, cfg_i.saturation});
		end else begin
			color_gain = UNIT_GAIN + 10'(cfg_i.saturation);
		end
		chroma_dev = signed'({2'b00, pix_i.chroma}) - signed'({2'b00, CHROMA_NEUTRAL});
		chroma_prod = chroma_dev * color_gain;
		chroma_prod = (chroma_prod >>> GAIN_SHIFT) + 20'(signed'({2'b00, CHROMA_NEUTRAL}));
		chroma_scaled = clamp_u8(chroma_prod);
		cored_dev = signed'({2'b00, chroma_scaled}) - signed'({2'b00, CHROMA_NEUTRAL});
		core_thr = (10'sd1 <<< cfg_i.core_mode) - 10'sd1;
		if (cored_dev <= core_thr && cored_dev >= -core_thr) begin
			chroma_scaled = CHROMA_NEUTRAL;
		end
		case (cfg_i.kill_mode)
			KILL_ON: begin
			end
			KILL_OFF: begin
				chroma_scaled = CHROMA_NEUTRAL;
			end
			default: begin
				if (!burst_ok_i) begin
					chroma_scaled = CHROMA_NEUTRAL;
				end
			end
		endcase
		st_nxt.valid = pix_valid_i;
		if (pix_valid_i) begin
			st_nxt.pix.luma   = clamp_u8(luma_prod);
			st_nxt.pix.chroma = chroma_scaled;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pix_valid_o = st_r.valid;
	assign pix_o       = st_r.pix;

endmodule

`default_nettype wire

// ==== hdl/vdc_pkg.sv ====
// Shared constants and types for the video decoder control register bank
package vdc_pkg;

	localparam int unsigned CLK_HZ    = 40_000_000;
	localparam int unsigned ADDR_W    = 8;
	localparam int unsigned IDX_W     = 6;
	localparam int unsigned SLOT_W    = 5;
	localparam int unsigned REG_CNT   = 20;

	// Register indices; the byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_BASE          = 6'h0d;
	localparam logic [IDX_W-1:0] IDX_FLOAT_DEMOD   = 6'h0d;
	localparam logic [IDX_W-1:0] IDX_GP_PORT       = 6'h0e;
	localparam logic [IDX_W-1:0] IDX_LUMA_CTL      = 6'h0f;
	localparam logic [IDX_W-1:0] IDX_PICTURE_GAIN  = 6'h10;
	localparam logic [IDX_W-1:0] IDX_LUMA_OFFSET   = 6'h11;
	localparam logic [IDX_W-1:0] IDX_CHROMA_A      = 6'h12;
	localparam logic [IDX_W-1:0] IDX_CHROMA_B      = 6'h13;
	localparam logic [IDX_W-1:0] IDX_DEMOD_STATUS  = 6'h14;
	localparam logic [IDX_W-1:0] IDX_COLOR_GAIN    = 6'h15;
	localparam logic [IDX_W-1:0] IDX_TINT          = 6'h16;
	localparam logic [IDX_W-1:0] IDX_VERT_A        = 6'h17;
	localparam logic [IDX_W-1:0] IDX_OUT_CTL       = 6'h1e;
	localparam logic [IDX_W-1:0] IDX_TEST_CTL      = 6'h20;

	// Field positions
	localparam int unsigned FLOAT_REQ_BIT  = 7;
	localparam int unsigned SEC_FORCE_BIT  = 6;
	localparam int unsigned SUBC_FOUND_BIT = 7;
	localparam int unsigned SEC_FOUND_BIT  = 6;
	localparam int unsigned MNSEC_LO       = 0;
	localparam int unsigned GROUP_LO       = 4;
	localparam int unsigned KILL_LO        = 0;
	localparam int unsigned CORE_LO        = 2;
	localparam int unsigned GAIN_TEST_BIT  = 0;
	localparam int unsigned FIVE_TAP_BIT   = 3;

	// Writable bits per register; all other bits read as zero, except demod status bits 7 and 6, which read the live detector flags
	localparam logic [7:0] MASK_FLOAT_DEMOD = 8'hd8;
	localparam logic [7:0] MASK_LUMA_CTL    = 8'h7f;
	localparam logic [7:0] MASK_DEMOD_CTL   = 8'h3f;
	localparam logic [7:0] MASK_OUT_CTL     = 8'h3f;
	localparam logic [7:0] MASK_TEST_CTL    = 8'h01;
	localparam logic [7:0] MASK_FULL        = 8'hff;

	localparam logic [7:0] RST_LUMA_CTL = 8'h04;
	localparam logic [7:0] RST_CHROMA_A = 8'h08;

	localparam logic [1:0] GRP_VIDEO  = 2'h0;
	localparam logic [1:0] GRP_TIMING = 2'h1;
	localparam logic [1:0] GRP_CLOCK  = 2'h2;

	localparam logic [1:0] KILL_ON  = 2'h2;
	localparam logic [1:0] KILL_OFF = 2'h3;

	localparam logic [1:0] SEC_FORCE_NOT = 2'h2;
	localparam logic [1:0] SEC_FORCE_YES = 2'h3;

	localparam logic [7:0]        CHROMA_NEUTRAL = 8'h80;
	localparam logic signed [9:0] UNIT_GAIN      = 10'sd128;
	localparam int unsigned       GAIN_SHIFT     = 7;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic [7:0] luma;
		logic [7:0] chroma;
	} vdc_pix_t;

	typedef struct packed {
		logic signed [7:0] contrast;
		logic signed [7:0] brightness;
		logic signed [7:0] saturation;
		logic              sat_unsigned;
		logic [1:0]        kill_mode;
		logic [1:0]        core_mode;
	} vdc_adj_cfg_t;

	typedef struct packed {
		logic [7:0] port_routing;
		logic [7:0] luma_ctl;
		logic [7:0] chroma_b;
		logic [5:0] demod_ctl;
		logic [7:0] tint;
		logic [7:0] vert_a;
	} vdc_cfg_t;

	function automatic logic [REG_CNT-1:0][7:0] reg_reset_image();
		logic [REG_CNT-1:0][7:0] img;
		img = '0;
		img[SLOT_W'(IDX_LUMA_CTL - IDX_BASE)] = RST_LUMA_CTL;
		img[SLOT_W'(IDX_CHROMA_A - IDX_BASE)] = RST_CHROMA_A;
		return img;
	endfunction

	localparam logic [REG_CNT-1:0][7:0] REG_RST = reg_reset_image();

endpackage

// ==== tb/vdc_ctrl_regs_props.sv ====
// Assertion checker for the video decoder control register bank
`timescale 1ns/10ps
`default_nettype none

module vdc_ctrl_regs_props
	import vdc_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	input wire logic        secam_found_i,
	input wire logic        pix_valid_i,
	input wire logic        pix_valid_o,
	input wire logic        video_oe_o,
	input wire logic        timing_oe_o,
	input wire logic        secam_filter_en_o,
	input wire vdc_cfg_t    cfg_o
);
	logic [1:0] sec_ovr;
	assign sec_ovr = cfg_o.demod_ctl[1:0];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Groups are nested, so timing never floats while video is driven
	property p_grp_nest;
		!timing_oe_o |-> !video_oe_o;
	endproperty
	a_grp_nest: assert property (p_grp_nest) else $error("timing floats, video driven");

	property p_sec_auto;
		!$past(rst_i) && $past(secam_found_i) && $past(sec_ovr) != SEC_FORCE_NOT
			|-> secam_filter_en_o;
	endproperty
	a_sec_auto: assert property (p_sec_auto) else $error("filter off with SECAM found");

	property p_sec_man;
		!$past(rst_i) && $past(sec_ovr) == SEC_FORCE_YES |-> secam_filter_en_o;
	endproperty
	a_sec_man: assert property (p_sec_man) else $error("filter off under forced SECAM");

	property p_b_hold;
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");

	property p_r_hold;
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");

	property p_w_lat;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
			|-> ##2 s_axi_bvalid_o;
	endproperty
	a_w_lat: assert property (p_w_lat) else $error("write response late");

	property p_r_lat;
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read response late");

	property p_pix;
		pix_valid_i |=> pix_valid_o;
	endproperty
	a_pix: assert property (p_pix) else $error("sample not passed on");
endmodule

bind vdc_ctrl_regs vdc_ctrl_regs_props i_vdc_ctrl_regs_props (
	.clk_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
	.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
	.s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .secam_found_i, .pix_valid_i,
	.pix_valid_o, .video_oe_o, .timing_oe_o, .secam_filter_en_o, .cfg_o
);

`default_nettype wire

// ==== tb/vdc_ctrl_regs_tb.sv ====
// Self-checking testbench for the video decoder control register bank
`timescale 1ns/10ps
`default_nettype none

module vdc_ctrl_regs_tb
	import vdc_pkg::*;
;
	logic              clk_i = '0;
	logic              rst_i = '1;
	logic [ADDR_W-1:0] s_axi_awaddr_i = '0;
	logic [ADDR_W-1:0] s_axi_araddr_i = '0;
	logic [31:0]       s_axi_wdata_i = '0;
	logic [3:0]        s_axi_wstrb_i = 4'h1;
	logic              s_axi_awvalid_i = '0, s_axi_wvalid_i = '0, s_axi_bready_i = '0;
	logic              s_axi_arvalid_i = '0, s_axi_rready_i = '0, pix_valid_i = '0;
	logic              output_drive_pin_n_i = '1, secam_found_i = '0;
	logic              subcarrier_found_i = '0, burst_ok_i = '1;
	vdc_pix_t          pix_i = '0, pix_o;
	logic              s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic              s_axi_arready_o, s_axi_rvalid_o, pix_valid_o;
	logic [1:0]        s_axi_bresp_o, s_axi_rresp_o;
	logic [31:0]       s_axi_rdata_o;
	logic              video_oe_o, timing_oe_o, clock_oe_o, secam_filter_en_o, five_tap_en_o;
	vdc_cfg_t          cfg_o;
	int                failures = 0, tests_run = 0;

	vdc_ctrl_regs i_vdc_ctrl_regs (
		.clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
		.s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
		.s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
		.s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .output_drive_pin_n_i,
		.secam_found_i, .subcarrier_found_i, .burst_ok_i, .pix_valid_i, .pix_i, .video_oe_o,
		.timing_oe_o, .clock_oe_o, .secam_filter_en_o, .five_tap_en_o, .cfg_o, .pix_valid_o,
		.pix_o
	);

	always #12.5 clk_i = ~clk_i;

	task automatic stop_test;
		if (failures == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tmo(input logic ok);
		if (!ok) begin
			failures++;
			stop_test();
		end
	endtask

	// Ready is raised late by dly cycles so the slave has to hold its answer
	task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er,
		input int dly);
		logic       b;
		logic       aw_hs;
		logic       w_hs;
		logic       b_hs;
		logic [1:0] resp;
		b = '0;
		s_axi_awaddr_i  <= {idx, 2'h0};
		s_axi_wdata_i   <= {24'h0, d};
		s_axi_awvalid_i <= '1;
		s_axi_wvalid_i  <= '1;
		s_axi_bready_i  <= (dly == 0);
		for (int n = 0; n < 100 && !b; n++) begin
			// Handshakes are judged mid-cycle, away from the edge that updates them
			@(negedge clk_i);
			aw_hs = s_axi_awvalid_i && s_axi_awready_o;
			w_hs  = s_axi_wvalid_i && s_axi_wready_o;
			b_hs  = s_axi_bvalid_o && s_axi_bready_i;
			resp  = s_axi_bresp_o;
			@(posedge clk_i);
			if (aw_hs) s_axi_awvalid_i <= '0;
			if (w_hs) s_axi_wvalid_i <= '0;
			if (b_hs) begin
				b = '1;
				chk("bresp", {30'h0, er}, {30'h0, resp});
			end else if (n >= dly) s_axi_bready_i <= '1;
		end
		tmo(b);
	endtask

	task automatic rd(input logic [5:0] idx, input logic [7:0] ed, input logic [1:0] er,
		input int dly);
		logic        b;
		logic        ar_hs;
		logic        r_hs;
		logic [31:0] data;
		logic [1:0]  resp;
		b = '0;
		s_axi_araddr_i  <= {idx, 2'h0};
		s_axi_arvalid_i <= '1;
		s_axi_rready_i  <= (dly == 0);
		for (int n = 0; n < 100 && !b; n++) begin
			@(negedge clk_i);
			ar_hs = s_axi_arvalid_i && s_axi_arready_o;
			r_hs  = s_axi_rvalid_o && s_axi_rready_i;
			data  = s_axi_rdata_o;
			resp  = s_axi_rresp_o;
			@(posedge clk_i);
			if (ar_hs) s_axi_arvalid_i <= '0;
			if (r_hs) begin
				b = '1;
				chk("rdata", {24'h0, ed}, data);
				chk("rresp", {30'h0, er}, {30'h0, resp});
			end else if (n >= dly) s_axi_rready_i <= '1;
		end
		tmo(b);
	endtask

	task automatic px(input logic [7:0] y, input logic [7:0] c, input logic bo,
		input logic [15:0] ex);
		pix_valid_i <= '1;
		pix_i       <= {y, c};
		burst_ok_i  <= bo;
		@(posedge clk_i);
		pix_valid_i <= '0;
		// The valid flag stands for one cycle only, so look mid-cycle
		@(negedge clk_i);
		chk("pix_valid", 32'h1, {31'h0, pix_valid_o});
		chk("pix", {16'h0, ex}, {16'h0, pix_o});
		@(posedge clk_i);
	endtask

	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= '0;
		for (int i = IDX_GP_PORT; i <= IDX_VERT_A; i++) rd(6'(i), i == IDX_LUMA_CTL ?
			RST_LUMA_CTL : i == IDX_CHROMA_A ? RST_CHROMA_A : 8'h00, RESP_OKAY, 0);
		chk("oe", 32'h7, {29'h0, video_oe_o, timing_oe_o, clock_oe_o});
		for (int i = IDX_GP_PORT; i <= IDX_VERT_A; i++) wr(6'(i), 8'hff, RESP_OKAY, i % 3);
		for (int i = IDX_GP_PORT; i <= IDX_VERT_A; i++) rd(6'(i), i == IDX_LUMA_CTL ?
			MASK_LUMA_CTL : i == IDX_DEMOD_STATUS ? MASK_DEMOD_CTL : 8'hff, RESP_OKAY, i % 3);
		chk("five_tap", 32'h1, {31'h0, five_tap_en_o});
		chk("cfg_a", 32'h0000_ff7f, {16'h0, cfg_o.port_routing, cfg_o.luma_ctl});
		chk("cfg_b", 32'h3fff_ffff, {2'h0, cfg_o.demod_ctl, cfg_o.chroma_b, cfg_o.tint, cfg_o.vert_a});
		secam_found_i      <= '1;
		subcarrier_found_i <= '1;
		rd(IDX_DEMOD_STATUS, 8'hff, RESP_OKAY, 0);
		wr(IDX_DEMOD_STATUS, 8'h00, RESP_OKAY, 0);
		rd(IDX_DEMOD_STATUS, 8'hc0, RESP_OKAY, 0);
		for (int k = 0; k < 4; k++) begin
			secam_found_i <= k[0];
			wr(IDX_FLOAT_DEMOD, {1'h0, k[1], 6'h0}, RESP_OKAY, 0);
			repeat (2) @(posedge clk_i);
			chk("secam_filter", {31'h0, k[0] | k[1]}, {31'h0, secam_filter_en_o});
		end
		wr(IDX_FLOAT_DEMOD, 8'h00, RESP_OKAY, 0);
		wr(IDX_DEMOD_STATUS, {6'h0, SEC_FORCE_NOT}, RESP_OKAY, 0);
		repeat (2) @(posedge clk_i);
		chk("secam_filter", 32'h0, {31'h0, secam_filter_en_o});
		for (int g = 0; g < 4; g++) begin
			wr(IDX_OUT_CTL, 8'(g << GROUP_LO), RESP_OKAY, 0);
			for (int m = 0; m < 3; m++) begin
				output_drive_pin_n_i <= (m != 1);
				wr(IDX_FLOAT_DEMOD, (m == 2) ? 8'h80 : 8'h00, RESP_OKAY, 0);
				repeat (2) @(posedge clk_i);
				chk("oe", {29'h0, m == 0 || g == 3 ? 3'h7 : g == 0 ? 3'h3 : g == 1 ? 3'h1 : 3'h0},
					{29'h0, video_oe_o, timing_oe_o, clock_oe_o});
			end
		end
		wr(IDX_PICTURE_GAIN, 8'hc0, RESP_OKAY, 0);
		wr(IDX_LUMA_OFFSET, 8'hf6, RESP_OKAY, 0);
		wr(IDX_COLOR_GAIN, 8'hc0, RESP_OKAY, 0);
		wr(IDX_CHROMA_A, 8'h08, RESP_OKAY, 0);
		px(8'hc8, 8'hc0, '1, 16'h5aa0);
		px(8'hc8, 8'hc0, '0, 16'h5a80);
		wr(IDX_COLOR_GAIN, 8'h00, RESP_OKAY, 0);
		px(8'hc8, 8'hc0, '1, 16'h5ac0);
		wr(IDX_COLOR_GAIN, 8'h40, RESP_OKAY, 0);
		px(8'hc8, 8'hc0, '1, 16'h5ae0);
		wr(IDX_CHROMA_A, 8'h0a, RESP_OKAY, 0);
		px(8'hc8, 8'hc0, '0, 16'h5ae0);
		wr(IDX_CHROMA_A, 8'h0b, RESP_OKAY, 0);
		px(8'hc8, 8'hc0, '1, 16'h5a80);
		wr(IDX_CHROMA_A, 8'h08, RESP_OKAY, 0);
		wr(IDX_TEST_CTL, 8'h01, RESP_OKAY, 0);
		px(8'hc8, 8'hc0, '1, 16'h5aa0);
		s_axi_wstrb_i <= 4'h0;
		wr(IDX_TINT, 8'h12, RESP_OKAY, 0);
		s_axi_wstrb_i <= 4'h1;
		rd(IDX_TINT, 8'hff, RESP_OKAY, 0);
		wr(6'h30, 8'h55, RESP_SLVERR, 0);
		rd(6'h30, 8'h00, RESP_SLVERR, 0);
		stop_test();
	end
endmodule

`default_nettype wire
